// [stamp_readout_pkg.sv]
// constants for the timestamp readout register bank
// assumes a 5-bit register address within the selected register page
package stamp_readout_pkg;

  // ==========================================================
  // register offsets
  localparam logic [4:0] write_data_checksum_off = 5'h1b;
  localparam logic [4:0] transmit_stamp_port_off = 5'h1c;
  localparam logic [4:0] receive_stamp_port_off = 5'h1d;
  localparam logic [4:0] event_queue_status_off = 5'h1e;

  // ==========================================================
  // reset values and limits
  localparam logic [15:0] word_zero = 16'h0000;
  localparam logic [1:0] stamp_overflow_max = 2'h3;
  localparam logic [2:0] missed_event_max = 3'h7;

  // ==========================================================
  // readout sequence lengths, last word index
  localparam logic [1:0] transmit_last_word = 2'h3;
  localparam logic [2:0] receive_last_word = 3'h5;

  // ==========================================================
  // event status field positions
  localparam int missed_event_count_lsb = 8;
  localparam int changed_word_count_lsb = 6;
  localparam int edge_direction_bit = 5;
  localparam int event_unit_index_lsb = 2;
  localparam int simultaneous_events_bit = 1;
  localparam int event_seen_bit = 0;

endpackage : stamp_readout_pkg

// [ones_sum16.sv]
// one's complement adder used by both running checksums
// assumes purely combinational use inside a clocked owner
`timescale 1ns/100ps
`default_nettype none

module ones_sum16 #(
  parameter int WIDTH = 16
) (
  input wire logic [WIDTH-1:0] sum_in,
  input wire logic [WIDTH-1:0] addend,
  output logic [WIDTH-1:0] sum_out
);

  // ==========================================================
  // end-around carry
  logic [WIDTH:0] raw;

  always_comb begin
    raw = {1'b0, sum_in} + {1'b0, addend};
    sum_out = raw[WIDTH-1:0] + {{(WIDTH-1){1'b0}}, raw[WIDTH]};
  end

endmodule : ones_sum16

`default_nettype wire

// [stamp_readout_regs.sv]
// page-4 timestamp readout bank: write checksum, transmit and receive
// stamp ports, event queue status
// assumes the capture logic offers stamps on core_clk with push strobes,
// and register strobes are single-cycle pulses on core_clk
`timescale 1ns/100ps
`default_nettype none

module stamp_readout_regs #(
  parameter int UNITS = 8
) (
  input wire logic core_clk,
  input wire logic nrst,
  // register access, page already decoded
  input wire logic page4_sel,
  input wire logic ctrl_frame,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // read checksum accumulator shared with its own register
  input wire logic read_sum_clear,
  output logic [15:0] read_sum_value,
  // transmit stamp capture
  input wire logic tx_push,
  input wire logic [29:0] tx_nanoseconds,
  input wire logic [31:0] tx_seconds,
  output logic tx_slot_free,
  // receive stamp capture
  input wire logic rx_push,
  input wire logic [29:0] rx_nanoseconds,
  input wire logic [31:0] rx_seconds,
  input wire logic [15:0] rx_sequence_id,
  input wire logic [3:0] rx_message_type,
  input wire logic [11:0] rx_source_hash,
  output logic rx_slot_free,
  // event capture
  input wire logic ev_push,
  input wire logic [UNITS-1:0] ev_detect,
  input wire logic [UNITS-1:0] ev_rise,
  input wire logic [29:0] ev_nanoseconds,
  input wire logic [31:0] ev_seconds,
  // event stamp handed over to the event data reader on each status read that finds an event held
  output logic event_data_valid,
  output logic event_ext_present,
  output logic [15:0] event_ext_status,
  output logic [29:0] event_nanoseconds,
  output logic [31:0] event_seconds
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [15:0] rdata;
    logic [15:0] wr_sum;
    logic [15:0] rd_sum;
    // transmit slot
    logic tx_valid;
    logic [29:0] tx_ns;
    logic [31:0] tx_sec;
    logic [1:0] tx_ovf;
    logic [1:0] tx_pend_ovf;
    logic [1:0] tx_idx;
    // receive slot
    logic rx_valid;
    logic [29:0] rx_ns;
    logic [31:0] rx_sec;
    logic [15:0] rx_seq;
    logic [3:0] rx_type;
    logic [11:0] rx_hash;
    logic [1:0] rx_ovf;
    logic [1:0] rx_pend_ovf;
    logic [2:0] rx_idx;
    // event head
    logic ev_valid;
    logic [15:0] ev_status;
    logic [15:0] ev_ext;
    logic [29:0] ev_ns;
    logic [31:0] ev_sec;
    logic [61:0] ev_prev;
    logic [UNITS-1:0][2:0] ev_missed;
    // event data hand-over
    logic out_valid;
    logic out_mult;
    logic [15:0] out_ext;
    logic [29:0] out_ns;
    logic [31:0] out_sec;
  } state_t;

  state_t cur, nxt;

  // ==========================================================
  // access decode
  logic wr_any, rd_any, acc_ok;
  logic rd_wsum, rd_tx, rd_rx, rd_est;
  logic [15:0] rd_word, wr_sum_added, rd_sum_added;
  assign wr_any = page4_sel && reg_wr;
  assign rd_any = page4_sel && reg_rd;
  assign acc_ok = !ctrl_frame;
  assign rd_wsum = rd_any &&
    (reg_addr == stamp_readout_pkg::write_data_checksum_off);
  assign rd_tx = rd_any &&
    (reg_addr == stamp_readout_pkg::transmit_stamp_port_off);
  assign rd_rx = rd_any &&
    (reg_addr == stamp_readout_pkg::receive_stamp_port_off);
  assign rd_est = rd_any &&
    (reg_addr == stamp_readout_pkg::event_queue_status_off);

  // ==========================================================
  // read data select, all reads of other offsets answer zero
  always_comb begin
    rd_word = stamp_readout_pkg::word_zero;
    if (rd_wsum) begin
      rd_word = cur.wr_sum;
    end else if (rd_tx && cur.tx_valid) begin
      unique case (cur.tx_idx)
        2'h0: rd_word = cur.tx_ns[15:0];
        2'h1: rd_word = {cur.tx_ovf, cur.tx_ns[29:16]};
        2'h2: rd_word = cur.tx_sec[15:0];
        2'h3: rd_word = cur.tx_sec[31:16];
      endcase
    end else if (rd_rx && cur.rx_valid) begin
      case (cur.rx_idx)
        3'h0: rd_word = cur.rx_ns[15:0];
        3'h1: rd_word = {cur.rx_ovf, cur.rx_ns[29:16]};
        3'h2: rd_word = cur.rx_sec[15:0];
        3'h3: rd_word = cur.rx_sec[31:16];
        3'h4: rd_word = cur.rx_seq;
        3'h5: rd_word = {cur.rx_type, cur.rx_hash};
        default: rd_word = stamp_readout_pkg::word_zero;
      endcase
    end else if (rd_est) begin
      rd_word = cur.ev_valid ? cur.ev_status : stamp_readout_pkg::word_zero;
    end
  end

  // ==========================================================
  // checksum adders
  // write data summed
  ones_sum16 #(.WIDTH(16)) u_wr_add (
    .sum_in(cur.wr_sum),
    .addend(reg_wdata),
    .sum_out(wr_sum_added)
  );

  ones_sum16 #(.WIDTH(16)) u_rd_add (
    .sum_in(cur.rd_sum),
    .addend(rd_word),
    .sum_out(rd_sum_added)
  );

  // ==========================================================
  // event status built from a new capture
  logic [15:0] new_status, new_ext;
  logic [2:0] unit_low, unit_miss, unit_sel;
  logic found_low, found_miss;
  logic [1:0] changed;
  logic [61:0] new_ts;
  always_comb begin
    unit_low = 3'h0;
    unit_miss = 3'h0;
    found_low = 1'b0;
    found_miss = 1'b0;
    new_ext = stamp_readout_pkg::word_zero;
    new_ts = {ev_seconds, ev_nanoseconds};
    // scan units from the top so the lowest index wins
    for (int i = UNITS - 1; i >= 0; i--) begin
      if (ev_detect[i]) begin
        unit_low = 3'(i);
        found_low = 1'b1;
        if (cur.ev_missed[i] != 3'h0) begin
          unit_miss = 3'(i);
          found_miss = 1'b1;
        end
      end
    end
    for (int i = 0; i < UNITS && i < 8; i++) begin
      new_ext[2*i] = ev_detect[i];
      new_ext[2*i+1] = ev_rise[i];
    end
    unit_sel = found_miss ? unit_miss : unit_low;
    if (new_ts[61:46] != cur.ev_prev[61:46]) begin
      changed = 2'h3;
    end else if (new_ts[45:30] != cur.ev_prev[45:30]) begin
      changed = 2'h2;
    end else if (new_ts[29:16] != cur.ev_prev[29:16]) begin
      changed = 2'h1;
    end else begin
      changed = 2'h0;
    end
    new_status = stamp_readout_pkg::word_zero;
    new_status[stamp_readout_pkg::missed_event_count_lsb +: 3] =
      cur.ev_missed[unit_sel];
    new_status[stamp_readout_pkg::changed_word_count_lsb +: 2] = changed;
    new_status[stamp_readout_pkg::edge_direction_bit] = ev_rise[unit_sel];
    new_status[stamp_readout_pkg::event_unit_index_lsb +: 3] = unit_sel;
    new_status[stamp_readout_pkg::simultaneous_events_bit] =
      (ev_detect & (ev_detect - UNITS'(1))) != '0;
    new_status[stamp_readout_pkg::event_seen_bit] = found_low;
  end

  // ==========================================================
  // next state
  logic tx_done, rx_done, ev_pop, ev_take;
  always_comb begin
    nxt = cur;
    nxt.rdata = rd_word;
    tx_done = rd_tx && cur.tx_valid &&
      (cur.tx_idx == stamp_readout_pkg::transmit_last_word);
    rx_done = rd_rx && cur.rx_valid &&
      (cur.rx_idx == stamp_readout_pkg::receive_last_word);
    ev_pop = rd_est && cur.ev_valid;
    ev_take = ev_push && (ev_detect != '0) && (!cur.ev_valid || ev_pop);

    // write checksum, clear on read wins over a same-cycle write
    if (wr_any && acc_ok) begin
      nxt.wr_sum = wr_sum_added;
    end
    if (rd_wsum) begin
      nxt.wr_sum = stamp_readout_pkg::word_zero;
    end
    if (read_sum_clear) begin
      nxt.rd_sum = stamp_readout_pkg::word_zero;
    end else if (acc_ok && (rd_wsum || rd_tx || rd_rx || rd_est)) begin
      nxt.rd_sum = rd_sum_added;
    end

    // transmit slot walk and refill
    if (rd_tx && cur.tx_valid) begin
      nxt.tx_idx = cur.tx_idx + 2'h1;
    end
    if (tx_done) begin
      nxt.tx_valid = 1'b0;
    end
    if (tx_push) begin
      if (!cur.tx_valid || tx_done) begin
        nxt.tx_valid = 1'b1;
        nxt.tx_ns = tx_nanoseconds;
        nxt.tx_sec = tx_seconds;
        nxt.tx_idx = 2'h0;
        nxt.tx_ovf = cur.tx_pend_ovf;
        nxt.tx_pend_ovf = 2'h0;
      end else if (cur.tx_pend_ovf !=
          stamp_readout_pkg::stamp_overflow_max) begin
        nxt.tx_pend_ovf = cur.tx_pend_ovf + 2'h1;
      end
    end

    // receive slot walk and refill
    if (rd_rx && cur.rx_valid) begin
      nxt.rx_idx = cur.rx_idx + 3'h1;
    end
    if (rx_done) begin
      nxt.rx_valid = 1'b0;
    end
    if (rx_push) begin
      if (!cur.rx_valid || rx_done) begin
        nxt.rx_valid = 1'b1;
        nxt.rx_ns = rx_nanoseconds;
        nxt.rx_sec = rx_seconds;
        nxt.rx_seq = rx_sequence_id;
        nxt.rx_type = rx_message_type;
        nxt.rx_hash = rx_source_hash;
        nxt.rx_idx = 3'h0;
        nxt.rx_ovf = cur.rx_pend_ovf;
        nxt.rx_pend_ovf = 2'h0;
      end else if (cur.rx_pend_ovf !=
          stamp_readout_pkg::stamp_overflow_max) begin
        nxt.rx_pend_ovf = cur.rx_pend_ovf + 2'h1;
      end
    end

    // event head: pop hands the stamp to the data reader
    nxt.out_valid = 1'b0;
    if (ev_pop) begin
      nxt.ev_valid = 1'b0;
      nxt.out_valid = 1'b1;
      nxt.out_mult = cur.ev_status[stamp_readout_pkg::simultaneous_events_bit];
      nxt.out_ext = cur.ev_ext;
      nxt.out_ns = cur.ev_ns;
      nxt.out_sec = cur.ev_sec;
    end
    if (ev_take) begin
      nxt.ev_valid = 1'b1;
      nxt.ev_status = new_status;
      nxt.ev_ext = new_ext;
      nxt.ev_ns = ev_nanoseconds;
      nxt.ev_sec = ev_seconds;
      nxt.ev_prev = new_ts;
    end
    // per-unit missed counters: reported units restart, lost ones count
    for (int i = 0; i < UNITS; i++) begin
      if (ev_push && ev_detect[i]) begin
        if (ev_take) begin
          nxt.ev_missed[i] = 3'h0;
        end else if (cur.ev_missed[i] !=
            stamp_readout_pkg::missed_event_max) begin
          nxt.ev_missed[i] = cur.ev_missed[i] + 3'h1;
        end
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  // ==========================================================
  // outputs straight from state
  assign reg_rdata = cur.rdata;
  assign read_sum_value = cur.rd_sum;
  assign tx_slot_free = !cur.tx_valid;
  assign rx_slot_free = !cur.rx_valid;
  assign event_data_valid = cur.out_valid;
  assign event_ext_present = cur.out_mult;
  assign event_ext_status = cur.out_ext;
  assign event_nanoseconds = cur.out_ns;
  assign event_seconds = cur.out_sec;

endmodule : stamp_readout_regs

`default_nettype wire

// [stamp_readout_regs_sva.sv]
// checker for the timestamp readout bank
// assumes binding onto stamp_readout_regs, one clock domain
`timescale 1ns/100ps
`default_nettype none

module stamp_readout_regs_sva (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic page4_sel,
  input wire logic ctrl_frame,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_rdata,
  input wire logic read_sum_clear,
  input wire logic [15:0] read_sum_value,
  input wire logic tx_push,
  input wire logic tx_slot_free,
  input wire logic event_data_valid,
  input wire logic event_ext_present
);
  // ==========================================================
  // helpers
  logic rd, rd_sum, rd_ev;
  // decoded page-4 reads
  assign rd = page4_sel && reg_rd;
  assign rd_sum = rd && reg_addr == stamp_readout_pkg::write_data_checksum_off;
  assign rd_ev = rd && reg_addr == stamp_readout_pkg::event_queue_status_off;

  // end-around carry add, kept apart from the design's adder
  function automatic logic [15:0] oc(input logic [15:0] a,
      input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction : oc

  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // ==========================================================
  // properties
  property p_sum_clear;
    rd_sum ##1 (rd_sum && !reg_wr) |=> reg_rdata == 16'h0000;
  endproperty
  a_sum_clear: assert property (p_sum_clear)
    else $error("write sum not cleared by read");
  property p_read_add;
    rd && !ctrl_frame && !read_sum_clear && reg_addr inside {[5'h1b:5'h1e]}
      |=> read_sum_value == oc($past(read_sum_value), reg_rdata);
  endproperty
  a_read_add: assert property (p_read_add)
    else $error("read value not added to read sum");
  property p_frame_hold;
    rd && ctrl_frame && !read_sum_clear |=> $stable(read_sum_value);
  endproperty
  a_frame_hold: assert property (p_frame_hold)
    else $error("control frame read changed read sum");
  property p_top_zero;
    rd_ev |=> reg_rdata[15:11] == 5'h00;
  endproperty
  a_top_zero: assert property (p_top_zero)
    else $error("status top bits not zero");
  property p_seen_valid;
    rd_ev |=> reg_rdata[0] == event_data_valid;
  endproperty
  a_seen_valid: assert property (p_seen_valid)
    else $error("event seen bit disagrees with handover");
  property p_valid_cause;
    event_data_valid |-> $past(rd_ev);
  endproperty
  a_valid_cause: assert property (p_valid_cause)
    else $error("event handover without status read");
  property p_ext_flag;
    event_data_valid |-> reg_rdata[1] == event_ext_present;
  endproperty
  a_ext_flag: assert property (p_ext_flag)
    else $error("multi event bit disagrees with extended flag");
  property p_tx_empty;
    rd && reg_addr == 5'h1c && tx_slot_free |=> reg_rdata == 16'h0000;
  endproperty
  a_tx_empty: assert property (p_tx_empty)
    else $error("empty transmit slot read not zero");
  property p_tx_take;
    tx_push && tx_slot_free |=> !tx_slot_free;
  endproperty
  a_tx_take: assert property (p_tx_take)
    else $error("transmit stamp not taken into free slot");
endmodule : stamp_readout_regs_sva

bind stamp_readout_regs stamp_readout_regs_sva sva_inst (.core_clk, .nrst,
  .page4_sel, .ctrl_frame, .reg_wr, .reg_rd, .reg_addr, .reg_rdata,
  .read_sum_clear, .read_sum_value, .tx_push, .tx_slot_free,
  .event_data_valid, .event_ext_present);
`default_nettype wire

// [stamp_readout_regs_test.sv]
// self-checking bench for the timestamp readout bank
// assumes the package and design files are compiled first
`timescale 1ns/100ps
`default_nettype none

module stamp_readout_regs_test;
  logic core_clk, nrst, page4_sel, ctrl_frame, reg_wr, reg_rd;
  logic read_sum_clear, tx_push, tx_slot_free, rx_push, rx_slot_free;
  logic ev_push, event_data_valid, event_ext_present;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, read_sum_value, sum;
  logic [15:0] rx_sequence_id, event_ext_status;
  logic [29:0] tx_nanoseconds, rx_nanoseconds, ev_nanoseconds;
  logic [29:0] event_nanoseconds;
  logic [31:0] tx_seconds, rx_seconds, ev_seconds, event_seconds;
  logic [3:0] rx_message_type;
  logic [11:0] rx_source_hash;
  logic [7:0] ev_detect, ev_rise;
  int n_errors, n_checks;

  stamp_readout_regs #(.UNITS(8)) stamp_readout_regs_inst (.core_clk, .nrst,
    .page4_sel, .ctrl_frame, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .read_sum_clear, .read_sum_value, .tx_push, .tx_nanoseconds,
    .tx_seconds, .tx_slot_free, .rx_push, .rx_nanoseconds, .rx_seconds,
    .rx_sequence_id, .rx_message_type, .rx_source_hash, .rx_slot_free,
    .ev_push, .ev_detect, .ev_rise, .ev_nanoseconds, .ev_seconds,
    .event_data_valid, .event_ext_present, .event_ext_status,
    .event_nanoseconds, .event_seconds);

  // ==========================================================
  // access tasks, each entered and left just after an edge
  function automatic logic [15:0] oc(input logic [15:0] a,
      input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction : oc

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // answer lands one edge after the strobe; back to back is allowed
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask : rd

  task automatic cap(input logic is_rx, input logic [29:0] ns,
      input logic [31:0] s, input logic [15:0] w4);
    {tx_push, rx_push} <= {!is_rx, is_rx};
    {tx_nanoseconds, rx_nanoseconds, tx_seconds, rx_seconds} <= {ns, ns, s, s};
    {rx_sequence_id, rx_message_type, rx_source_hash} <= {w4, ns[15:0]};
    @(posedge core_clk);
    {tx_push, rx_push} <= 2'h0;
    #1;
  endtask : cap

  task automatic ev(input logic [7:0] d, input logic [7:0] r,
      input logic [29:0] ns, input logic [31:0] s);
    {ev_push, ev_detect, ev_rise} <= {1'b1, d, r};
    {ev_nanoseconds, ev_seconds} <= {ns, s};
    @(posedge core_clk);
    ev_push <= 1'b0;
    #1;
  endtask : ev

  // reads a whole stamp; rx word5 is fed from the low ns word above
  task automatic stamp(input logic [4:0] a, input logic [29:0] ns,
      input logic [31:0] s, input logic [1:0] ov, input logic [15:0] w4);
    logic [15:0] w [6];
    w = '{ns[15:0], {ov, ns[29:16]}, s[15:0], s[31:16], w4, ns[15:0]};
    for (int i = 0; i < (a == 5'h1d ? 6 : 4); i++) begin
      rd(a, w[i]);
    end
  endtask : stamp

  task automatic results;
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  // ==========================================================
  // clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    results;
  end

  // ==========================================================
  // main sequence
  initial begin
    {nrst, page4_sel, ctrl_frame, reg_wr, reg_rd, read_sum_clear} = '0;
    {reg_addr, reg_wdata, tx_push, rx_push, ev_push, ev_detect, ev_rise} = '0;
    {tx_nanoseconds, rx_nanoseconds, ev_nanoseconds} = '0;
    {tx_seconds, rx_seconds, ev_seconds, rx_sequence_id} = '0;
    {rx_message_type, rx_source_hash} = '0;
    repeat (8) @(posedge core_clk);
    {nrst, page4_sel} <= 2'h3;
    @(posedge core_clk);
    #1;
    check({14'h0000, tx_slot_free, rx_slot_free}, 16'h0003);
    rd(5'h1c, 16'h0000);
    rd(5'h1e, 16'h0000);
    rd(5'h05, 16'h0000);
    // sum of page writes, frame and other page left out
    read_sum_clear <= 1'b1;
    wr(5'h10, 16'hfff0);
    read_sum_clear <= 1'b0;
    wr(5'h11, 16'h0020);
    wr(5'h1b, 16'h8000);
    wr(5'h1a, 16'h0001);
    ctrl_frame <= 1'b1;
    wr(5'h10, 16'h1234);
    {ctrl_frame, page4_sel} <= 2'h0;
    wr(5'h10, 16'h4321);
    page4_sel <= 1'b1;
    sum = oc(oc(oc(16'hfff0, 16'h0020), 16'h8000), 16'h0001);
    rd(5'h1b, sum);
    check(read_sum_value, sum);
    rd(5'h1b, 16'h0000);
    wr(5'h12, 16'h0005);
    ctrl_frame <= 1'b1;
    rd(5'h1b, 16'h0005);
    ctrl_frame <= 1'b0;
    check(read_sum_value, sum);
    rd(5'h1b, 16'h0000);
    // dropped stamps reported on next stamp
    cap(1'b0, 30'h2abc_1234, 32'h1111_2222, 16'h0000);
    repeat (5) cap(1'b0, 30'h0000_0000, 32'h0000_0000, 16'h0000);
    stamp(5'h1c, 30'h2abc_1234, 32'h1111_2222, 2'h0, 16'h0000);
    cap(1'b0, 30'h0155_aa00, 32'h8000_0001, 16'h0000);
    stamp(5'h1c, 30'h0155_aa00, 32'h8000_0001, 2'h3, 16'h0000);
    cap(1'b1, 30'h3fff_95a5, 32'h0000_ffff, 16'hbeef);
    cap(1'b1, 30'h0000_0000, 32'h0000_0000, 16'h0000);
    stamp(5'h1d, 30'h3fff_95a5, 32'h0000_ffff, 2'h0, 16'hbeef);
    cap(1'b1, 30'h0000_20ff, 32'h0000_0003, 16'h0001);
    stamp(5'h1d, 30'h0000_20ff, 32'h0000_0003, 2'h1, 16'h0001);
    // misses on unit 5 saturate while head is held
    ev(8'h01, 8'h01, 30'h0000_0010, 32'h0000_0000);
    repeat (9) ev(8'h20, 8'h20, 30'h0000_0000, 32'h0000_0000);
    wr(5'h1e, 16'hffff);
    rd(5'h1e, 16'h0021);
    check({event_data_valid, event_nanoseconds[14:0]}, 16'h8010);
    check({event_ext_present, event_seconds[14:0]}, 16'h0000);
    ev(8'h24, 8'h20, 30'h0001_0010, 32'h0000_0001);
    rd(5'h1e, 16'h07b7);
    check(event_ext_status, 16'h0c10);
    check({event_ext_present, event_seconds[14:0]}, 16'h8001);
    check(event_nanoseconds[29:14], 16'h0004);
    ev(8'h02, 8'h00, 30'h0002_0011, 32'h0001_0002);
    rd(5'h1e, 16'h00c5);
    rd(5'h1e, 16'h0000);
    // hand-over pulse lasts one cycle only
    check({15'h0000, event_data_valid}, 16'h0000);
    results;
  end
endmodule : stamp_readout_regs_test
`default_nettype wire
